/* aic_pkg.sv */
package aic_pkg;
    // Register byte addresses (word-aligned, Avalon-MM)
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_SRC   = 4'h4;
    localparam logic [3:0] ADDR_AMP   = 4'h8;
    localparam logic [3:0] ADDR_BGAP  = 4'hC;
    localparam logic [3:0] ADDR_RHI   = 4'h0 + 4'h0;
    localparam int         ADDR_W     = 4;
    // Control register 0 fields
    localparam int CTL_START  = 7;
    localparam int CTL_BUSY   = 6;
    localparam int CTL_EN     = 5;
    localparam int CTL_FMT    = 4;
    // Source/clock register fields
    localparam int SRC_LSB    = 4;
    localparam int DIV_LSB    = 0;
    // Amplifier/reference register fields
    localparam int AMP_EN     = 7;
    localparam int AMP_INSEL  = 4;
    localparam int REF_LSB    = 2;
    localparam int GAIN_LSB   = 0;
    // Write masks of implemented bits
    localparam logic [7:0] MASK_CTRL0 = 8'hBF;
    localparam logic [7:0] MASK_SRC   = 8'hF7;
    localparam logic [7:0] MASK_AMP   = 8'h9F;
    localparam logic [7:0] MASK_BGAP  = 8'h01;
    localparam logic [7:0] RST_VAL    = 8'h00;
    // Result register addresses
    localparam logic [3:0] ADDR_RESH  = 4'h1;
    localparam logic [3:0] ADDR_RESL  = 4'h2;
    localparam int         CHAN_LAST  = 11;
    localparam int         CONV_CYCLES = 14;
    localparam int         DIV_W       = 7;
    // Analog input routing selection
    typedef enum logic [2:0] {
        AIC_SEL_EXT, AIC_SEL_AVDD, AIC_SEL_AMP, AIC_SEL_GND
    } aic_insrc_e;
    typedef enum logic [1:0] {
        AIC_REF_AVDD, AIC_REF_PIN, AIC_REF_AMP
    } aic_ref_e;
    typedef enum logic [1:0] {
        AIC_IDLE, AIC_ARMED, AIC_CONV
    } aic_state_e;
endpackage

/* aic_adc_ctrl.sv */
// Function
// - Format bit 0: high=D11..4, low=D3..0 top; bit 1: high=D11..8, low=D7..0.
// - Channel codes 0000..1011 route external input n to the converter.
// - Channel codes 1100..1111 connect no external input; converter input floats.
// - Source codes 0000, 0100, 11xx select the external channel.
// - Source codes 0001/0010/0011 route supply, half, quarter.
// - Source codes 0101/0110/0111 route amplifier output, half, quarter.
// - Source codes 10xx connect converter input to ground.
// - Any internal source disconnects every external channel.
// - Unimplemented register bits read as zero.
// - Conversion clock is system clock divided by two to the divider code.
// - Amplifier powered when its enable bit is one.
// - Amplifier input from reference pin at 0, bandgap at 1.
// - Bandgap chosen as amplifier input disconnects the reference-input pin.
// - Reference code 00 supply, 01 external pin, 1x amplifier output.
// - Internal reference selected disconnects the external reference pin.
// - Gain code 00..11 gives 1, 1.667, 2.5, 3.333.
// - Bandgap powered when its enable bit is one.
// - Start bit high then low starts conversion; busy set until done.
// - Results unchanged while disabled; unused result bits read zero.
`timescale 1ns/1ps
`default_nettype none
module aic_adc_ctrl #(
    parameter int CONV_LEN = aic_pkg::CONV_CYCLES
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Converter core
    input  wire logic [11:0] conv_data_in,
    output logic             conv_clk_en_out,
    output logic             converter_enable_out,
    output logic             conversion_busy_flag_out,
    // Analog mux controls
    output logic [11:0]      external_analog_inputs_out,
    output logic [3:0]       internal_source_sel_out,
    output logic             input_ground_out,
    // Reference and amplifier controls
    output logic [2:0]       reference_switch_out,
    output logic             amplifier_enable_out,
    output logic [1:0]       amplifier_gain_select_out,
    output logic             amp_ref_pin_connect_out,
    output logic             amp_bandgap_connect_out,
    output logic             bandgap_enable_out
);
    import aic_pkg::*;

    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  src;
        logic [7:0]  amp;
        logic [7:0]  bgap;
        logic [11:0] result;
        logic [6:0]  div_cnt;
        logic        tick;
        logic [7:0]  conv_cnt;
        aic_state_e  state;
        logic        ack;
        logic [31:0] rdata;
    } aic_state_s;

    aic_state_s st_q;
    aic_state_s st_d;

    // Divider terminal count: 2**code - 1
    function automatic logic [6:0] div_limit(input logic [2:0] code);
        logic [7:0] full;
        full = 8'h01 << code;
        return 7'(full - 8'h01);
    endfunction

    // Result byte placement per format bit
    function automatic logic [15:0] place(input logic [11:0] d,
                                          input logic fmt);
        if (fmt)
            return {4'h0, d};
        else
            return {d, 4'h0};
    endfunction

    logic [3:0] chan;
    logic [3:0] insrc;
    logic       ext_sel;
    logic [15:0] res_pair;

    // Field decode shared by logic and outputs
    always_comb
    begin
        chan     = st_q.ctrl0[3:0];
        insrc    = st_q.src[SRC_LSB +: 4];
        ext_sel  = (insrc == 4'h0) || (insrc == 4'h4)
                   || (insrc[3:2] == 2'b11);
        res_pair = place(st_q.result, st_q.ctrl0[CTL_FMT]);
    end

    // Next-state logic: bus, divider, conversion sequence
    always_comb
    begin
        logic [7:0] wb;
        wb   = avs_writedata_in[7:0];
        st_d = st_q;
        st_d.ack = 1'b0;
        // One wait cycle gives every access a fixed two-cycle answer
        if ((avs_read_in || avs_write_in) && !st_q.ack)
        begin
            st_d.ack = 1'b1;
            if (avs_write_in)
            begin
                case (avs_address_in)
                    ADDR_CTRL0: st_d.ctrl0 = (wb & MASK_CTRL0)
                                           | (st_q.ctrl0 & ~MASK_CTRL0);
                    ADDR_SRC:   st_d.src  = wb & MASK_SRC;
                    ADDR_AMP:   st_d.amp  = wb & MASK_AMP;
                    ADDR_BGAP:  st_d.bgap = wb & MASK_BGAP;
                    default: ;
                endcase
            end
            else
            begin
                case (avs_address_in)
                    ADDR_CTRL0: st_d.rdata = {24'h0, st_q.ctrl0};
                    ADDR_SRC:   st_d.rdata = {24'h0, st_q.src};
                    ADDR_AMP:   st_d.rdata = {24'h0, st_q.amp};
                    ADDR_BGAP:  st_d.rdata = {24'h0, st_q.bgap};
                    ADDR_RESH:  st_d.rdata = {24'h0, res_pair[15:8]};
                    ADDR_RESL:  st_d.rdata = {24'h0, res_pair[7:0]};
                    default:    st_d.rdata = 32'h0;
                endcase
            end
        end
        // Conversion clock enable from the divider
        st_d.tick = 1'b0;
        if (st_q.div_cnt >= div_limit(st_q.src[DIV_LSB +: 3]))
        begin
            st_d.div_cnt = 7'h00;
            st_d.tick    = 1'b1;
        end
        else
            st_d.div_cnt = st_q.div_cnt + 7'h01;
        // Start sequence: high then low, only while enabled
        case (st_q.state)
            AIC_IDLE:
                if (st_q.ctrl0[CTL_START] && st_q.ctrl0[CTL_EN])
                    st_d.state = AIC_ARMED;
            AIC_ARMED:
                if (!st_q.ctrl0[CTL_EN])
                    st_d.state = AIC_IDLE;
                else if (!st_q.ctrl0[CTL_START])
                begin
                    st_d.state = AIC_CONV;
                    st_d.conv_cnt = 8'h00;
                    st_d.ctrl0[CTL_BUSY] = 1'b1;
                end
            AIC_CONV:
                if (!st_q.ctrl0[CTL_EN])
                begin
                    // Aborted: results keep old value
                    st_d.state = AIC_IDLE;
                    st_d.ctrl0[CTL_BUSY] = 1'b0;
                end
                else if (st_q.tick)
                begin
                    if (st_q.conv_cnt == 8'(CONV_LEN - 1))
                    begin
                        st_d.state  = AIC_IDLE;
                        st_d.result = conv_data_in;
                        st_d.ctrl0[CTL_BUSY] = 1'b0;
                    end
                    else
                        st_d.conv_cnt = st_q.conv_cnt + 8'h01;
                end
            default: st_d.state = AIC_IDLE;
        endcase
    end

    // State register, all zero on reset
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // Bus answers
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st_q.ack;
    assign avs_readdata_out    = st_q.rdata;

    // Continuous analog-side decodes
    always_comb
    begin
        external_analog_inputs_out = 12'h000;
        if (ext_sel && chan <= 4'(CHAN_LAST))
            external_analog_inputs_out[chan] = 1'b1;
        internal_source_sel_out = ext_sel ? 4'h0 : insrc;
        input_ground_out = (insrc[3:2] == 2'b10);
        case (st_q.amp[REF_LSB +: 2])
            2'b00:   reference_switch_out = 3'b001;
            2'b01:   reference_switch_out = 3'b010;
            default: reference_switch_out = 3'b100;
        endcase
    end

    assign amplifier_enable_out      = st_q.amp[AMP_EN];
    assign amplifier_gain_select_out = st_q.amp[GAIN_LSB +: 2];
    assign amp_ref_pin_connect_out   = !st_q.amp[AMP_INSEL];
    assign amp_bandgap_connect_out   = st_q.amp[AMP_INSEL];
    assign bandgap_enable_out        = st_q.bgap[0];
    assign conv_clk_en_out           = st_q.tick;
    assign converter_enable_out      = st_q.ctrl0[CTL_EN];
    assign conversion_busy_flag_out  = st_q.ctrl0[CTL_BUSY];

    // Checks
    AST_GND: assert property (@(posedge mclk_in) disable iff (rst_in)
        input_ground_out |-> external_analog_inputs_out == 12'h000)
        else $error("ground selected with channel on");
    AST_INT_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
        (internal_source_sel_out != 4'h0) |-> external_analog_inputs_out == 12'h0)
        else $error("external channel on with internal source");
    AST_FLOAT: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.ctrl0[3:2] == 2'b11) |-> external_analog_inputs_out == 12'h0)
        else $error("channel on for floating code");
    AST_ONEHOT: assert property (@(posedge mclk_in) disable iff (rst_in)
        $countones(external_analog_inputs_out) <= 1)
        else $error("more than one channel on");
    AST_RSV: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_q.src[3] == 1'b0 && st_q.amp[6:5] == 2'b00 && st_q.bgap[7:1] == 7'h0)
        else $error("reserved bit set");
    AST_DIV0: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.src[2:0] == 3'h1 && $stable(st_q.src) && conv_clk_en_out)
        |=> !conv_clk_en_out)
        else $error("divide by two ticks back to back");
    AST_BUSY: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.state == AIC_ARMED && st_q.ctrl0[CTL_EN] && !st_q.ctrl0[CTL_START])
        |=> conversion_busy_flag_out)
        else $error("busy not set after start");
    AST_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
        !st_q.ctrl0[CTL_EN] |=> $stable(st_q.result))
        else $error("result changed while disabled");
    AST_BG: assert property (@(posedge mclk_in) disable iff (rst_in)
        amp_bandgap_connect_out |-> !amp_ref_pin_connect_out)
        else $error("pin and bandgap both on amplifier");
    AST_REF: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_q.amp[3] |-> reference_switch_out == 3'b100)
        else $error("external reference pin still connected");

    // Further checks on the routing, bus and conversion paths

    // Selected channel is the one and only switch closed
    AST_EXT_ROUTE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (ext_sel && chan <= 4'(CHAN_LAST)) |-> external_analog_inputs_out == (12'h001 << chan))
        else $error("wrong external channel routed");

    // External codes must never raise an internal path
    AST_EXT_SEL: assert property (@(posedge mclk_in) disable iff (rst_in)
        ext_sel |-> internal_source_sel_out == 4'h0 && !input_ground_out)
        else $error("internal path on for external code");

    // Supply fractions pass their code to the mux
    AST_SRC_SUP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (insrc >= 4'h1 && insrc <= 4'h3) |-> internal_source_sel_out == insrc)
        else $error("supply source not routed");

    // Amplifier fractions pass their code to the mux
    AST_SRC_AMP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (insrc >= 4'h5 && insrc <= 4'h7) |-> internal_source_sel_out == insrc)
        else $error("amplifier source not routed");

    // Every ground code closes the ground switch
    AST_GND_CODE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (insrc[3:2] == 2'b10) |-> input_ground_out)
        else $error("ground not selected");

    // Undivided clock ticks on every cycle once settled
    AST_DIV_ONE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.src[2:0] == 3'h0) |=> conv_clk_en_out)
        else $error("undivided clock missed a tick");

    // Amplifier power follows its enable bit
    AST_AMPEN: assert property (@(posedge mclk_in) disable iff (rst_in)
        amplifier_enable_out == st_q.amp[AMP_EN])
        else $error("amplifier power wrong");

    // Pin feeds the amplifier whenever the bandgap is not chosen
    AST_PIN_SEL: assert property (@(posedge mclk_in) disable iff (rst_in)
        !st_q.amp[AMP_INSEL] |-> amp_ref_pin_connect_out && !amp_bandgap_connect_out)
        else $error("amplifier input select wrong");

    // Supply reference code
    AST_REF_SUP: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.amp[3:2] == 2'b00) |-> reference_switch_out == 3'b001)
        else $error("supply reference not selected");

    // External pin reference code
    AST_REF_PIN: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.amp[3:2] == 2'b01) |-> reference_switch_out == 3'b010)
        else $error("pin reference not selected");

    // Gain code passes straight through
    AST_GAIN: assert property (@(posedge mclk_in) disable iff (rst_in)
        amplifier_gain_select_out == st_q.amp[GAIN_LSB +: 2])
        else $error("gain code wrong");

    // Bandgap power follows its enable bit
    AST_BGEN: assert property (@(posedge mclk_in) disable iff (rst_in)
        bandgap_enable_out == st_q.bgap[0])
        else $error("bandgap power wrong");

    // Left-justified pair
    AST_FMT0: assert property (@(posedge mclk_in) disable iff (rst_in)
        !st_q.ctrl0[CTL_FMT] |-> res_pair == {st_q.result, 4'h0})
        else $error("left format wrong");

    // Right-justified pair, top nibble zero
    AST_FMT1: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_q.ctrl0[CTL_FMT] |-> res_pair == {4'h0, st_q.result})
        else $error("right format wrong");

    // Abort clears busy on the next cycle
    AST_ABORT: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.state == AIC_CONV && !st_q.ctrl0[CTL_EN]) |=> !conversion_busy_flag_out)
        else $error("busy stuck after abort");

    // Last tick latches the core data and clears busy
    AST_DONE: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q.state == AIC_CONV && st_q.ctrl0[CTL_EN] && st_q.tick
         && st_q.conv_cnt == 8'(CONV_LEN - 1))
        |=> !conversion_busy_flag_out && st_q.result == $past(conv_data_in))
        else $error("conversion end not handled");

    // Upper read data bits never set
    AST_RD_HI: assert property (@(posedge mclk_in) disable iff (rst_in)
        avs_readdata_out[31:8] == 24'h000000)
        else $error("upper read data set");

    // A fresh request always waits one cycle
    AST_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((avs_read_in || avs_write_in) && !st_q.ack) |-> avs_waitrequest_out)
        else $error("request answered without wait");

    // Request seen without ack is acknowledged next cycle
    AST_ACK: assert property (@(posedge mclk_in) disable iff (rst_in)
        ((avs_read_in || avs_write_in) && !st_q.ack) |=> st_q.ack)
        else $error("request not acknowledged");
endmodule
`default_nettype wire

/* aic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aic_core_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        busy_in,
    input  wire logic [11:0] sample_in,
    output logic      [11:0] conv_data_out
);
    logic [11:0] churn_q;
    // Lines wander outside a conversion, so a stale capture is caught
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            churn_q <= 12'h5A5;
        else
            churn_q <= churn_q + 12'h3C7;
    end
    // Result stands only while the conversion runs
    assign conv_data_out = busy_in ? sample_in : ~sample_in ^ churn_q;
endmodule
`default_nettype wire

/* adc_input_reference_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module adc_input_reference_control_tb_top;
    import aic_pkg::*;
    logic        mclk_in, rst_in, avs_read_in, avs_write_in;
    logic [3:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    logic        avs_waitrequest_out, clk_en, busy, gnd, ampen, pin, bgc, bgen;
    logic [11:0] conv_data, sample, chans;
    logic [3:0]  isel, s;
    logic [2:0]  refsw;
    logic [1:0]  gain;
    logic [7:0]  a, g;
    logic [15:0] er;
    int          miscompares, n_compared, cycles, cnt, i;
    aic_adc_ctrl #(.CONV_LEN(4)) uut (.mclk_in(mclk_in), .rst_in(rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .conv_data_in(conv_data),
        .conv_clk_en_out(clk_en), .converter_enable_out(),
        .conversion_busy_flag_out(busy), .external_analog_inputs_out(chans),
        .internal_source_sel_out(isel), .input_ground_out(gnd),
        .reference_switch_out(refsw), .amplifier_enable_out(ampen),
        .amplifier_gain_select_out(gain), .amp_ref_pin_connect_out(pin),
        .amp_bandgap_connect_out(bgc), .bandgap_enable_out(bgen));
    aic_core_model core (.mclk_in(mclk_in), .rst_in(rst_in), .busy_in(busy),
        .sample_in(sample), .conv_data_out(conv_data));
    // Free-running clock and hang guard
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] ad,
                       input logic [7:0] d, output logic [31:0] rd);
        logic w;
        @(posedge mclk_in);
        avs_address_in <= ad;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        // Waitrequest and read data seen as they stand at the rising edge
        do
        begin
            @(posedge mclk_in);
            w = avs_waitrequest_out;
            rd = avs_readdata_out;
        end while (w !== 1'b0);
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
    endtask
    function automatic logic is_ext(logic [3:0] c);
        return c == 4'h0 || c == 4'h4 || c[3:2] == 2'b11;
    endfunction
    function automatic logic [15:0] exp_res(logic f, logic [11:0] d);
        return f ? {4'h0, d} : {d, 4'h0};
    endfunction
    initial
    begin
        mclk_in = 0; rst_in = 1; avs_read_in = 0; avs_write_in = 0;
        avs_address_in = 4'h0; avs_writedata_in = 32'h0; sample = 12'h000;
        void'($urandom(27));
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        // Power-on values of registers and decodes
        for (i = 0; i < 4; i++)
        begin
            bus(0, 4'(i * 4), 8'h00, q);
            `CHK("reset reg", 32'h0, q)
        end
        `CHK("reset ref", 3'h1, refsw)
        `CHK("reset chan", 12'h001, chans)
        bus(0, 4'h3, 8'h00, q);
        `CHK("unmapped", 32'h0, q)
        $display("test reset done");
        // Random routing, reference and amplifier settings
        repeat (40)
        begin
            a = 8'($urandom);
            g = 8'($urandom);
            s = a[7:4];
            bus(1, ADDR_SRC, a, q);
            bus(1, ADDR_CTRL0, {4'h0, 4'($urandom)}, q);
            bus(0, ADDR_SRC, 8'h00, q);
            `CHK("src rb", {24'h0, a & 8'hF7}, q)
            bus(0, ADDR_CTRL0, 8'h00, q);
            `CHK("chan", (is_ext(s) && q[3:0] <= 4'hB) ? 12'h001 << q[3:0] :
                 12'h000, chans)
            `CHK("isel", is_ext(s) ? 4'h0 : s, isel)
            `CHK("gnd", s[3:2] == 2'b10, gnd)
            a = 8'($urandom);
            // Software enables the amplifier exactly when it is used
            a[7] = (s >= 4'h5 && s <= 4'h7) || a[3];
            g[0] = g[0] | a[4];
            bus(1, ADDR_BGAP, g, q);
            bus(1, ADDR_AMP, a, q);
            bus(0, ADDR_AMP, 8'h00, q);
            `CHK("amp rb", {24'h0, a & 8'h9F}, q)
            bus(0, ADDR_BGAP, 8'h00, q);
            `CHK("bg rb", {24'h0, g & 8'h01}, q)
            `CHK("ref", a[3] ? 3'h4 : (a[2] ? 3'h2 : 3'h1), refsw)
            `CHK("ampen", a[7], ampen)
            `CHK("gain", a[1:0], gain)
            `CHK("pin", !a[4], pin)
            `CHK("bgc", a[4], bgc)
            `CHK("bgen", g[0], bgen)
        end
        $display("test routing done");
        // Pulse rate of the conversion clock for every divider code
        for (i = 0; i < 8; i++)
        begin
            bus(1, ADDR_SRC, 8'(i), q);
            repeat (128) @(posedge mclk_in);
            cnt = 0;
            repeat (256)
            begin
                @(negedge mclk_in);
                cnt += (clk_en === 1'b1);
            end
            `CHK("div", 256 >> i, cnt)
        end
        $display("test divider done");
        // Conversions in both result formats
        bus(1, ADDR_SRC, 8'h00, q);
        for (i = 0; i < 4; i++)
        begin
            sample <= 12'($urandom);
            bus(1, ADDR_CTRL0, {3'b101, i[0], 4'h0}, q);
            bus(1, ADDR_CTRL0, {3'b001, i[0], 4'h0}, q);
            for (cnt = 0; cnt < 20 && busy !== 1'b1; cnt++) @(negedge mclk_in);
            `CHK("busy set", 1'b1, busy)
            for (cnt = 0; cnt < 300 && busy !== 1'b0; cnt++) @(negedge mclk_in);
            `CHK("busy clr", 1'b0, busy)
            er = exp_res(i[0], sample);
            bus(0, ADDR_RESH, 8'h00, q);
            `CHK("res hi", {24'h0, er[15:8]}, q)
            bus(0, ADDR_RESL, 8'h00, q);
            `CHK("res lo", {24'h0, er[7:0]}, q)
        end
        // Start while disabled leaves the result alone
        bus(1, ADDR_CTRL0, 8'h90, q);
        bus(1, ADDR_CTRL0, 8'h10, q);
        repeat (20) @(posedge mclk_in);
        bus(0, ADDR_RESL, 8'h00, q);
        er = exp_res(1'b1, sample);
        `CHK("kept", {24'h0, er[7:0]}, q)
        $display("test conversion done");
        give_verdict();
    end
endmodule
`default_nettype wire
